// [rtl/periodic_wave_fifo_player.sv]
// Wrapping FIFO with APB control and a two-pass signed playback sequencer
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wave_map.svh"
module periodic_wave_fifo_player #(
  parameter int DEPTH = `WAVE_DEPTH,
  parameter int WIDTH = `WAVE_WIDTH
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               load_valid,
  input  wire logic [WIDTH-1:0]   load_data,
  output logic                    load_ready,
  output logic                    fifo_rd_req,
  output wave_pkg::flags_t        flags,
  output wave_pkg::sample_t       wave_out,
  output logic                    irq
);
  import wave_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  if (WIDTH != 8 || DEPTH < 4 || DEPTH != (1 << AW) || CW > 16)
  begin : g_chk
    $error("player needs 8-bit words and a power-of-two depth up to 32768");
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  ctrl_t            ctrl_reg, ctrl_next;
  logic [CW-1:0]    af_reg, af_next, ae_reg, ae_next;
  logic [3:0]       mask_reg, mask_next;
  logic [31:0]      prdata_next;
  logic             pready_next, pslverr_next;
  logic             xfer, rd_status_clear;

  // Every access takes one wait state: pready rises on the second access cycle
  assign xfer = psel && penable && pready;
  assign rd_status_clear = xfer && !pwrite && (paddr == `INT_STATUS_OFS);

  logic [CW-1:0]    count_reg, count_next;
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [3:0]       status_reg, status_next, events;
  flags_t           flags_next;

  always_comb
  begin
    ctrl_next    = ctrl_reg;
    af_next      = af_reg;
    ae_next      = ae_reg;
    mask_next    = mask_reg;
    prdata_next  = prdata;
    pready_next  = psel && penable && !pready;
    pslverr_next = 1'b0;
    if (psel && penable && !pready)
    begin
      prdata_next = '0;
      unique case (paddr)
        `CTRL_OFS:       prdata_next = 32'(ctrl_reg);
        `STATUS_OFS:     prdata_next = 32'(flags);
        `INT_STATUS_OFS: prdata_next = 32'(status_reg);
        `INT_MASK_OFS:   prdata_next = 32'(mask_reg);
        `AF_LEVEL_OFS:   prdata_next = 32'(af_reg);
        `AE_LEVEL_OFS:   prdata_next = 32'(ae_reg);
        `POINTERS_OFS:   prdata_next = {16'(wr_ptr_reg), 16'(rd_ptr_reg)};
        default:         pslverr_next = 1'b1;
      endcase
    end
    if (xfer && pwrite)
    begin
      unique case (paddr)
        `CTRL_OFS:     ctrl_next = ctrl_t'(pwdata[2:0]);
        `INT_MASK_OFS: mask_next = pwdata[3:0];
        `AF_LEVEL_OFS: af_next   = pwdata[CW-1:0];
        `AE_LEVEL_OFS: ae_next   = pwdata[CW-1:0];
        default:       ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= ctrl_t'(`CTRL_RESET);
      af_reg   <= CW'(`AF_LEVEL_RESET);
      ae_reg   <= CW'(`AE_LEVEL_RESET);
      mask_reg <= `INT_MASK_RESET;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      af_reg   <= af_next;
      ae_reg   <= ae_next;
      mask_reg <= mask_next;
      prdata   <= prdata_next;
      pready   <= pready_next;
      pslverr  <= pslverr_next;
    end
  end

  // ----------------------------------------------------------------
  // FIFO counters and flags
  // ----------------------------------------------------------------
  logic             wr_accept, rd_advance, rd_halted, wrap_mode;
  logic             load_ready_next, rd_req_next;
  logic [WIDTH-1:0] mem_rd_data;

  assign wrap_mode  = !ctrl_reg.read_halt_at_empty;
  assign rd_halted  = ctrl_reg.read_halt_at_empty && flags.empty;
  assign rd_advance = fifo_rd_req && !rd_halted;
  assign wr_accept  = load_valid && load_ready;

  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (wr_accept)
    begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (rd_advance)
    begin
      rd_ptr_next = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
    end
    // Wrapping reads replay the table, so only halting reads consume words
    if (wr_accept && !(rd_advance && !wrap_mode) && count_reg != FULL_COUNT)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (!wr_accept && rd_advance && !wrap_mode)
    begin
      count_next = count_reg - 1'b1;
    end
    flags_next.full              = (count_next == FULL_COUNT);
    flags_next.empty             = wrap_mode ? (rd_ptr_next == LAST)
                                             : (count_next == '0);
    flags_next.almost_full_flag  = (count_next >= af_next);
    flags_next.almost_empty_flag = (count_next <= ae_next);
    load_ready_next = !(flags_next.full && ctrl_next.write_halt_at_full);
    rd_req_next     = ctrl_next.play_en;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      flags       <= '{almost_empty_flag: 1'b1, almost_full_flag: 1'b0,
                       empty: 1'b1, full: 1'b0};
      load_ready  <= 1'b1;
      fifo_rd_req <= 1'b0;
    end
    else
    begin
      wr_ptr_reg  <= wr_ptr_next;
      rd_ptr_reg  <= rd_ptr_next;
      count_reg   <= count_next;
      flags       <= flags_next;
      load_ready  <= load_ready_next;
      fifo_rd_req <= rd_req_next;
    end
  end

  wave_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk     (pclk),
    .rstn    (presetn),
    .wr_en   (wr_accept),
    .wr_addr (wr_ptr_reg),
    .wr_data (load_data),
    .rd_en   (rd_advance),
    .rd_addr (rd_ptr_reg),
    .rd_data (mem_rd_data)
  );

  // ----------------------------------------------------------------
  // Playback sequencer
  // ----------------------------------------------------------------
  half_t            half_reg, half_next;
  logic             sign_reg, sign_next, flip;
  sample_t          wave_next;

  // Samples until enable are zero-sign reads of stale data; the player idles
  assign flip = fifo_rd_req && flags.empty;

  always_comb
  begin
    half_next = half_reg;
    sign_next = sign_reg;
    if (flip)
    begin
      unique case (half_reg)
        pos_half:
        begin
          half_next = neg_half;
          sign_next = 1'b1;
        end
        neg_half:
        begin
          half_next = pos_half;
          sign_next = 1'b0;
        end
      endcase
    end
    wave_next = '{sign: sign_reg, data: mem_rd_data};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_reg <= pos_half;
      sign_reg <= 1'b0;
      wave_out <= '0;
    end
    else
    begin
      half_reg <= half_next;
      sign_reg <= sign_next;
      wave_out <= wave_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, read to clear
  // ----------------------------------------------------------------
  logic             irq_next;

  always_comb
  begin
    events[`EV_FULL_BIT]  = flags_next.full && !flags.full;
    events[`EV_EMPTY_BIT] = flags_next.empty && !flags.empty;
    events[`EV_FLIP_BIT]  = flip;
    events[`EV_DROP_BIT]  = load_valid && !load_ready;
    // A new event beats the clear of the same read
    status_next = (rd_status_clear ? 4'h0 : status_reg) | events;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq        <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wrap_last;
    wrap_mode && rd_advance && rd_ptr_reg == LAST;
  endsequence

  sequence s_restart;
    rd_ptr_reg == '0 ##0 !flags.empty;
  endsequence

  a_wr_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg.write_halt_at_full && flags.full |=> $stable(wr_ptr_reg))
    else $error("write address moved while full and halting");

  a_rd_stop: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg.read_halt_at_empty && flags.empty |=> $stable(rd_ptr_reg))
    else $error("read address moved while empty and halting");

  a_rd_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    s_wrap_last |=> rd_ptr_reg == '0)
    else $error("read address did not wrap to zero");

  a_empty_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_wrap_last ##0 flags.empty |=> s_restart)
    else $error("wrap empty pulse lasted more than one cycle");

  // Full may only rise on the edge that stores a word
  a_full_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags.full) |-> $past(wr_accept))
    else $error("full flag rose without a stored word");

  a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
    !fifo_rd_req |=> $stable(sign_reg) && $stable(rd_ptr_reg))
    else $error("sequencer moved while disabled");

  a_sign_flip: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_rd_req && flags.empty |=> sign_reg != $past(sign_reg))
    else $error("polarity did not toggle at end of pass");

  a_sample_fmt: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> wave_out == {$past(sign_reg), $past(mem_rd_data)})
    else $error("sample is not polarity above read data");

  a_req_follow: assert property (@(posedge pclk) disable iff (!presetn)
    xfer && pwrite && paddr == `CTRL_OFS |=> fifo_rd_req == $past(pwdata[2]))
    else $error("read request does not follow enable");

  a_rd_step: assert property (@(posedge pclk) disable iff (!presetn)
    rd_advance && rd_ptr_reg != LAST |=> rd_ptr_reg == $past(rd_ptr_reg) + 1'b1)
    else $error("read address did not step by one");

endmodule
`default_nettype wire

// [rtl/wave_map.svh]
// Register offsets, field positions, reset values and limits of the wave player
//
// Contract
// - With write halt set, the write address freezes while full.
// - With read halt set, the read address stops once empty.
// - With read halt clear, the read address wraps from last to zero.
// - In wrap mode empty is high one cycle at the last address.
// - Addresses are internal; full, empty, almost full, almost empty are outputs.
// - The buffer holds 1024 words of 8 bits.
// - The half cycle is read twice per period, polarity flips per pass.
// - The sequencer idles until enable is set after loading.
// - State and polarity toggle on a clock edge when enable and empty are high.
// - Each edge registers a 9-bit sample: polarity above the 8-bit data.
// - Reset forces positive half, polarity zero and a zero sample.
// - The read request follows enable outside reset; reads pause only at empty with read halt set.
`ifndef WAVE_MAP_SVH
`define WAVE_MAP_SVH

`define CTRL_OFS        8'h00
`define STATUS_OFS      8'h04
`define INT_STATUS_OFS  8'h08
`define INT_MASK_OFS    8'h0c
`define AF_LEVEL_OFS    8'h10
`define AE_LEVEL_OFS    8'h14
`define POINTERS_OFS    8'h18

`define CTRL_WR_HALT_BIT  0
`define CTRL_RD_HALT_BIT  1
`define CTRL_PLAY_BIT     2

`define EV_FULL_BIT     0
`define EV_EMPTY_BIT    1
`define EV_FLIP_BIT     2
`define EV_DROP_BIT     3
`define EV_BITS         4

`define CTRL_RESET      3'h0
`define AF_LEVEL_RESET  11'h3fe
`define AE_LEVEL_RESET  11'h001
`define INT_MASK_RESET  4'h0

`define WAVE_DEPTH      1024
`define WAVE_WIDTH      8

`endif

// [rtl/wave_mem.sv]
// Simple dual-port word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module wave_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH != (1 << AW))
  begin : g_chk
    $error("wave_mem depth must be two to the address width");
  end

  // The array has no reset so it can map onto block memory
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= '0;
    end
    else if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// [rtl/wave_pkg.sv]
// Types shared by the wave player and its testbench
package wave_pkg;

  typedef struct packed {
    logic play_en;
    logic read_halt_at_empty;
    logic write_halt_at_full;
  } ctrl_t;

  typedef struct packed {
    logic almost_empty_flag;
    logic almost_full_flag;
    logic empty;
    logic full;
  } flags_t;

  typedef struct packed {
    logic       sign;
    logic [7:0] data;
  } sample_t;

  typedef enum logic {pos_half, neg_half} half_t;

endpackage

// [test/testbench.sv]
// Self-checking bench for the periodic wave player
`timescale 1ns/1ps
`default_nettype none
`include "wave_map.svh"
module testbench;
  import wave_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        load_valid;
  logic [7:0]  load_data;
  logic        load_ready;
  logic        fifo_rd_req;
  flags_t      flags;
  sample_t     wave_out;
  logic        irq;
  logic        ld_start;
  logic        ld_done;
  logic [7:0]  key;
  logic [31:0] rdat;
  logic [31:0] p1;
  logic        err;
  logic [3:0]  mask;
  logic        mon_on;
  logic        wrap_chk;
  logic        prev_ok;
  logic        prev_empty;
  logic        prev_sign;
  logic        flip_d1;
  logic        flip_d2;
  int          error_cnt;
  int          n_tests;
  int          n;
  int          gap;
  int          n_wrap;
  int          synced;
  int          ridx;
  int          r1;
  int          r2;

  periodic_wave_fifo_player periodic_wave_fifo_player_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .load_valid(load_valid),
    .load_data(load_data), .load_ready(load_ready), .fifo_rd_req(fifo_rd_req),
    .flags(flags), .wave_out(wave_out), .irq(irq)
  );

  wave_loader wave_loader_inst (
    .pclk(pclk), .presetn(presetn), .start(ld_start), .key(key),
    .load_ready(load_ready), .load_valid(load_valid), .load_data(load_data),
    .done(ld_done)
  );

  function automatic logic [7:0] tbl(input int i);
    return 8'(i * 37) ^ key;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Starts one edge late so a release and a new setup never share a time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk("apb_timeout", 32'h0, 32'h1);
      end_sim();
    end
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask

  // ----------------------------------------
  // Stream monitor
  // ----------------------------------------
  always @(negedge pclk)
  begin
    if (mon_on)
    begin
      if (prev_ok)
        chk("sign", wave_out.sign, prev_sign ^ flip_d2);
      if (wrap_chk)
      begin
        if (prev_empty)
          chk("empty_pulse", flags.empty, 1'b0);
        if (flags.empty && synced > 0)
          chk("wrap_period", gap, 1023);
        gap    = flags.empty ? 0 : gap + 1;
        n_wrap = n_wrap + int'(flags.empty);
        ridx   = flags.empty ? 1023 : (ridx + 1) % 1024;
        if (flags.empty || synced > 0)
          synced++;
        // Two register stages between the read address and the sample
        if (synced > 2)
          chk("sample", wave_out.data, tbl(r2));
        r2 = r1;
        r1 = ridx;
      end
      prev_empty = flags.empty;
      prev_sign  = wave_out.sign;
      // A flip shows in the sample two edges after the flag that caused it
      flip_d2    = flip_d1;
      flip_d1    = flags.empty & fifo_rd_req;
      prev_ok    = 1'b1;
    end
  end

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ld_start = 1'b0;
    {mon_on, wrap_chk, prev_ok, flip_d1, flip_d2} = 5'h00;
    {error_cnt, n_tests, gap, n_wrap, synced, ridx, r1, r2} = '0;
    key = 8'($urandom(98));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("flags_rst", flags, 32'ha);
    chk("wave_rst", wave_out, 32'h0);
    chk("req_rst", fifo_rd_req, 32'h0);
    chk("irq_rst", irq, 32'h0);
    mon_on = 1'b1;
    rdchk("ctrl_rst", `CTRL_OFS, 32'h0);
    rdchk("af_rst", `AF_LEVEL_OFS, 32'h3fe);
    rdchk("ae_rst", `AE_LEVEL_OFS, 32'h1);
    rdchk("mask_rst", `INT_MASK_OFS, 32'h0);
    rdchk("unmapped", 8'h1c, 32'h0);
    chk("unmapped_err", err, 32'h1);
    apb(1'b1, `CTRL_OFS, 32'h1);
    ld_start <= 1'b1;
    n = 0;
    while (!ld_done && n < 1200)
    begin
      @(posedge pclk);
      n++;
    end
    chk("load_done", ld_done, 32'h1);
    if (!ld_done)
      end_sim();
    settle(2);
    chk("full", flags.full, 32'h1);
    chk("ready_full", load_ready, 32'h0);
    rdchk("status_full", `STATUS_OFS, 32'h5);
    apb(1'b1, `CTRL_OFS, 32'h5);
    wrap_chk = 1'b1;
    settle(1);
    chk("req_on", fifo_rd_req, 32'h1);
    settle(2200);
    chk("wraps", n_wrap >= 2, 32'h1);
    wrap_chk = 1'b0;
    apb(1'b1, `CTRL_OFS, 32'h7);
    settle(2);
    n = 0;
    while (flags.empty !== 1'b1 && n < 1200)
    begin
      settle(0);
      n++;
    end
    chk("halt_empty", flags.empty, 32'h1);
    if (flags.empty !== 1'b1)
      end_sim();
    apb(1'b0, `POINTERS_OFS, 32'h0);
    p1 = rdat;
    settle(8);
    chk("halt_flag", flags.empty, 32'h1);
    apb(1'b0, `POINTERS_OFS, 32'h0);
    chk("halt_ptr", rdat[15:0], p1[15:0]);
    apb(1'b1, `CTRL_OFS, 32'h0);
    settle(1);
    chk("req_off", fifo_rd_req, 32'h0);
    mask = 4'($urandom);
    apb(1'b1, `INT_MASK_OFS, {28'h0, mask});
    settle(1);
    chk("irq_mask", irq, |(mask & 4'h7));
    rdchk("int_status", `INT_STATUS_OFS, 32'h7);
    rdchk("int_clear", `INT_STATUS_OFS, 32'h0);
    settle(1);
    chk("irq_clear", irq, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire

// [test/wave_loader.sv]
// Model of the table loader that fills the player once before playback
`timescale 1ns/1ps
`default_nettype none
module wave_loader (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [7:0] key,
  input  wire logic       load_ready,
  output logic            load_valid,
  output logic      [7:0] load_data,
  output logic            done
);
  logic [10:0] idx;
  // Word i of the table is 8'(i*37) xor key
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx        <= 11'h000;
      load_valid <= 1'b0;
      load_data  <= 8'h00;
    end
    else if (start && idx == 11'h000 && !load_valid)
    begin
      load_valid <= 1'b1;
      load_data  <= key;
    end
    else if (load_valid && load_ready)
    begin
      idx        <= idx + 11'h001;
      load_valid <= (idx != 11'h3ff);
      // A released bus must not keep showing the last word
      load_data  <= (idx == 11'h3ff) ? ~load_data : 8'((idx + 1) * 37) ^ key;
    end
  end
  assign done = (idx == 11'h400);
endmodule
`default_nettype wire
